//--- hdl/status_event_regs.svh
`ifndef STATUS_EVENT_REGS_SVH
`define STATUS_EVENT_REGS_SVH

// Event status register bit positions, reset value and used bits
`define SE_ESR_OPC        0
`define SE_ESR_QUERY      2
`define SE_ESR_DEVICE     3
`define SE_ESR_EXEC       4
`define SE_ESR_CMD        5
`define SE_ESR_PON        7
`define SE_ESR_RESET      8'h80
`define SE_ESR_USED       8'hBD

// Questionable register bit positions and used bits
`define SE_QUES_INTEG     9
`define SE_QUES_LIMIT     10
`define SE_QUES_USED      16'h0600

// Limit registers: used bits, trace split
`define SE_LIM1_USED      16'h7FFF
`define SE_LIM2_USED      16'h0006
`define SE_LIM1_TRACES    14
`define SE_LIM2_T15       1
`define SE_LIM2_T16       2
`define SE_TRACE15_IDX    14
`define SE_TRACE16_IDX    15

// Status byte bit positions
`define SE_STB_ERRQ       2
`define SE_STB_QUES       3
`define SE_STB_MAV        4
`define SE_STB_ESB        5
`define SE_STB_MSS        6
`define SE_STB_OPER       7

// Error queue entry codes, two's complement
`define SE_ERR_DEVICE     16'hFED4
`define SE_ERR_EXEC       16'hFF38
`define SE_ERR_CMD        16'hFF9C

`endif

//--- hdl/status_event_pkg.sv
package status_event_pkg;

    // Common command codes on the command port
    typedef enum logic [3:0] {
        CMD_PRE_WR  = 4'h1,
        CMD_PRE_RD  = 4'h2,
        CMD_IST_RD  = 4'h3,
        CMD_ESE_WR  = 4'h4,
        CMD_ESE_RD  = 4'h5,
        CMD_ESR_RD  = 4'h6,
        CMD_STB_RD  = 4'h7,
        CMD_OPC     = 4'h8,
        CMD_QUES_RD = 4'h9,
        CMD_QUES_EN = 4'hA,
        CMD_LIM1_RD = 4'hB,
        CMD_LIM1_EN = 4'hC,
        CMD_LIM2_RD = 4'hD,
        CMD_LIM2_EN = 4'hE
    } cmd_t;

    // Operation-complete tracker states
    typedef enum logic [1:0] {
        OPC_IDLE = 2'b01,
        OPC_WAIT = 2'b10
    } opc_state_t;

endpackage

//--- hdl/status_event_reg.sv
`timescale 1ns/1ps
`default_nettype none

module status_event_reg #(
    parameter int          WIDTH     = 16,
    parameter logic [15:0] USED      = 16'hFFFF,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] setBits,
    input  wire logic             clearRead,
    input  wire logic             enWrite,
    input  wire logic [WIDTH-1:0] enData,
    output var  logic [WIDTH-1:0] eventBits,
    output var  logic [WIDTH-1:0] enableBits,
    output logic                  summary
);

    // Sticky event bits, set beats clear-on-read
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    eventBits[i] <= RESET_VAL[i];
                end else if (clkEn) begin
                    eventBits[i] <= USED[i] & ((eventBits[i] & ~clearRead) | setBits[i]);
                end
            end
        end
    endgenerate

    // Enable mask, untouched by reads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enableBits <= '0;
        end else if (clkEn && enWrite) begin
            enableBits <= enData & USED[WIDTH-1:0];
        end
    end

    // AND with enable, OR across bits
    assign summary = |(eventBits & enableBits);

    // Unused event and enable bits stay clear
    property p_noUnused;
        @(posedge clk) disable iff (!rst_n)
        ((eventBits | enableBits) & ~USED[WIDTH-1:0]) == '0;
    endproperty
    a_noUnused: assert property (p_noUnused) else $error("unused status bit is set");

endmodule

`default_nettype wire

//--- hdl/status_event_aggregator.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_event_regs.svh"

module status_event_aggregator (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        cmdValid,
    input  wire logic [3:0]  cmdCode,
    input  wire logic [15:0] cmdData,
    output var  logic        respValid,
    output var  logic [15:0] respData,
    input  wire logic        opcIdle,
    input  wire logic        queryErr,
    input  wire logic        deviceErr,
    input  wire logic        execErr,
    input  wire logic        commandErr,
    input  wire logic        summarySourceA,
    input  wire logic [15:0] traceFail,
    input  wire logic        errQueueNotEmpty,
    input  wire logic        msgAvailable,
    input  wire logic        serviceRequest,
    output var  logic        errPush,
    output var  logic [15:0] errCode,
    output var  logic [7:0]  statusByte,
    output var  logic        individualStatus
);

    status_event_pkg::cmd_t       cmd;
    status_event_pkg::opc_state_t opcState;
    logic [7:0]  ppeMask;
    logic [7:0]  esrBits;
    logic [7:0]  eseBits;
    logic [7:0]  esrSet;
    logic [15:0] quesBits;
    logic [15:0] quesEn;
    logic [15:0] quesSet;
    logic [15:0] lim1Bits;
    logic [15:0] lim1En;
    logic [15:0] lim1Set;
    logic [15:0] lim2Bits;
    logic [15:0] lim2En;
    logic [15:0] lim2Set;
    logic        esbSum;
    logic        quesSum;
    logic        lim1Sum;
    logic        lim2Sum;
    logic        opcDone;
    logic        cmdGo;
    logic [7:0]  next_stb;

    assign cmd   = status_event_pkg::cmd_t'(cmdCode);
    assign cmdGo = cmdValid & clkEn;

    // Operation-complete tracker
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opcState <= status_event_pkg::OPC_IDLE;
        end else if (clkEn) begin
            case (opcState)
                status_event_pkg::OPC_IDLE: begin
                    if (cmdValid && cmd == status_event_pkg::CMD_OPC) begin
                        opcState <= status_event_pkg::OPC_WAIT;
                    end
                end
                status_event_pkg::OPC_WAIT: begin
                    if (opcIdle) begin
                        opcState <= status_event_pkg::OPC_IDLE;
                    end
                end
                default: begin
                    opcState <= status_event_pkg::OPC_IDLE;
                end
            endcase
        end
    end

    assign opcDone = (opcState == status_event_pkg::OPC_WAIT) && opcIdle;

    // Event status set sources
    always_comb begin
        esrSet                 = 8'h00;
        esrSet[`SE_ESR_OPC]    = opcDone;
        esrSet[`SE_ESR_QUERY]  = queryErr;
        esrSet[`SE_ESR_DEVICE] = deviceErr;
        esrSet[`SE_ESR_EXEC]   = execErr;
        esrSet[`SE_ESR_CMD]    = commandErr;
    end

    // Event status register and its enable mask
    status_event_reg #(
        .WIDTH    (8),
        .USED     ({8'h00, `SE_ESR_USED}),
        .RESET_VAL({8'h00, `SE_ESR_RESET})
    ) u_esr (
        .clk       (clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .setBits   (esrSet),
        .clearRead (cmdValid && cmd == status_event_pkg::CMD_ESR_RD),
        .enWrite   (cmdValid && cmd == status_event_pkg::CMD_ESE_WR),
        .enData    (cmdData[7:0]),
        .eventBits (esrBits),
        .enableBits(eseBits),
        .summary   (esbSum)
    );

    // Limit high: traces 15 and 16
    always_comb begin
        lim2Set              = 16'h0000;
        lim2Set[`SE_LIM2_T15] = traceFail[`SE_TRACE15_IDX];
        lim2Set[`SE_LIM2_T16] = traceFail[`SE_TRACE16_IDX];
    end

    status_event_reg #(
        .WIDTH    (16),
        .USED     (`SE_LIM2_USED),
        .RESET_VAL(16'h0000)
    ) u_lim2 (
        .clk       (clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .setBits   (lim2Set),
        .clearRead (cmdValid && cmd == status_event_pkg::CMD_LIM2_RD),
        .enWrite   (cmdValid && cmd == status_event_pkg::CMD_LIM2_EN),
        .enData    (cmdData),
        .eventBits (lim2Bits),
        .enableBits(lim2En),
        .summary   (lim2Sum)
    );

    // Limit low: summary of high in bit 0, traces 1..14 above
    assign lim1Set = {1'b0, traceFail[`SE_LIM1_TRACES-1:0], lim2Sum};

    status_event_reg #(
        .WIDTH    (16),
        .USED     (`SE_LIM1_USED),
        .RESET_VAL(16'h0000)
    ) u_lim1 (
        .clk       (clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .setBits   (lim1Set),
        .clearRead (cmdValid && cmd == status_event_pkg::CMD_LIM1_RD),
        .enWrite   (cmdValid && cmd == status_event_pkg::CMD_LIM1_EN),
        .enData    (cmdData),
        .eventBits (lim1Bits),
        .enableBits(lim1En),
        .summary   (lim1Sum)
    );

    // Questionable register sources
    always_comb begin
        quesSet                 = 16'h0000;
        quesSet[`SE_QUES_INTEG] = summarySourceA;
        quesSet[`SE_QUES_LIMIT] = lim1Sum;
    end

    status_event_reg #(
        .WIDTH    (16),
        .USED     (`SE_QUES_USED),
        .RESET_VAL(16'h0000)
    ) u_ques (
        .clk       (clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .setBits   (quesSet),
        .clearRead (cmdValid && cmd == status_event_pkg::CMD_QUES_RD),
        .enWrite   (cmdValid && cmd == status_event_pkg::CMD_QUES_EN),
        .enData    (cmdData),
        .eventBits (quesBits),
        .enableBits(quesEn),
        .summary   (quesSum)
    );

    // Parallel poll mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ppeMask <= 8'h00;
        end else if (cmdGo && cmd == status_event_pkg::CMD_PRE_WR) begin
            ppeMask <= cmdData[7:0];
        end
    end

    // Status byte contents
    always_comb begin
        next_stb               = 8'h00;
        next_stb[`SE_STB_ERRQ] = errQueueNotEmpty;
        next_stb[`SE_STB_QUES] = quesSum;
        next_stb[`SE_STB_MAV]  = msgAvailable;
        next_stb[`SE_STB_ESB]  = esbSum;
        next_stb[`SE_STB_MSS]  = serviceRequest;
        next_stb[`SE_STB_OPER] = 1'b0;
    end

    // Status byte and individual flag, bit 6 included
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            statusByte       <= 8'h00;
            individualStatus <= 1'b0;
        end else if (clkEn) begin
            statusByte       <= next_stb;
            individualStatus <= |(next_stb & ppeMask);
        end
    end

    // Error queue push, device error first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            errPush <= 1'b0;
            errCode <= 16'h0000;
        end else if (clkEn) begin
            errPush <= deviceErr | execErr | commandErr;
            if (deviceErr) begin
                errCode <= `SE_ERR_DEVICE;
            end else if (execErr) begin
                errCode <= `SE_ERR_EXEC;
            end else if (commandErr) begin
                errCode <= `SE_ERR_CMD;
            end
        end
    end

    // Query answers, one cycle after the command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            respValid <= 1'b0;
            respData  <= 16'h0000;
        end else if (clkEn) begin
            respValid <= 1'b0;
            if (cmdValid) begin
                case (cmd)
                    status_event_pkg::CMD_PRE_RD: begin
                        respValid <= 1'b1;
                        respData  <= {8'h00, ppeMask};
                    end
                    status_event_pkg::CMD_IST_RD: begin
                        respValid <= 1'b1;
                        respData  <= {15'h0000, individualStatus};
                    end
                    status_event_pkg::CMD_ESE_RD: begin
                        respValid <= 1'b1;
                        respData  <= {8'h00, eseBits};
                    end
                    status_event_pkg::CMD_ESR_RD: begin
                        respValid <= 1'b1;
                        respData  <= {8'h00, esrBits};
                    end
                    status_event_pkg::CMD_STB_RD: begin
                        respValid <= 1'b1;
                        respData  <= {8'h00, statusByte};
                    end
                    status_event_pkg::CMD_QUES_RD: begin
                        respValid <= 1'b1;
                        respData  <= quesBits;
                    end
                    status_event_pkg::CMD_LIM1_RD: begin
                        respValid <= 1'b1;
                        respData  <= lim1Bits;
                    end
                    status_event_pkg::CMD_LIM2_RD: begin
                        respValid <= 1'b1;
                        respData  <= lim2Bits;
                    end
                    default: begin
                        respValid <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Checks
    sequence s_esrRead;
        clkEn && cmdValid && cmd == status_event_pkg::CMD_ESR_RD && esrSet == 8'h00;
    endsequence

    sequence s_opcWait;
        clkEn && cmdValid && cmd == status_event_pkg::CMD_OPC
            && opcState == status_event_pkg::OPC_IDLE ##1 clkEn && opcIdle;
    endsequence

    property p_ist;
        @(posedge clk) disable iff (!rst_n)
        clkEn |=> individualStatus == |($past(next_stb) & $past(ppeMask));
    endproperty
    a_ist: assert property (p_ist) else $error("individual flag mismatch");

    property p_esrClear;
        @(posedge clk) disable iff (!rst_n)
        s_esrRead |=> respValid && respData[7:0] == $past(esrBits) && esrBits == 8'h00;
    endproperty
    a_esrClear: assert property (p_esrClear) else $error("event read not destructive");

    property p_esb;
        @(posedge clk) disable iff (!rst_n)
        clkEn |=> statusByte[`SE_STB_ESB] == |($past(esrBits) & $past(eseBits));
    endproperty
    a_esb: assert property (p_esb) else $error("event summary bit wrong");

    property p_opc;
        @(posedge clk) disable iff (!rst_n)
        s_opcWait |=> esrBits[`SE_ESR_OPC];
    endproperty
    a_opc: assert property (p_opc) else $error("operation complete not set");

    property p_query;
        @(posedge clk) disable iff (!rst_n)
        clkEn && queryErr |=> esrBits[`SE_ESR_QUERY];
    endproperty
    a_query: assert property (p_query) else $error("query error not flagged");

    property p_devErr;
        @(posedge clk) disable iff (!rst_n)
        clkEn && deviceErr |=> errPush && errCode == `SE_ERR_DEVICE && esrBits[`SE_ESR_DEVICE];
    endproperty
    a_devErr: assert property (p_devErr) else $error("device error not queued");

    property p_oper;
        @(posedge clk) disable iff (!rst_n)
        !statusByte[`SE_STB_OPER];
    endproperty
    a_oper: assert property (p_oper) else $error("operation summary set");

    property p_integ;
        @(posedge clk) disable iff (!rst_n)
        clkEn && summarySourceA |=> quesBits[`SE_QUES_INTEG];
    endproperty
    a_integ: assert property (p_integ) else $error("summary_source_a summary lost");

    property p_trace16;
        @(posedge clk) disable iff (!rst_n)
        clkEn && traceFail[`SE_TRACE16_IDX] |=> lim2Bits[`SE_LIM2_T16];
    endproperty
    a_trace16: assert property (p_trace16) else $error("trace 16 fail lost");

endmodule

`default_nettype wire

//--- verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic        clk,
    output var  logic        cmdValid,
    output var  logic [3:0]  cmdCode,
    output var  logic [15:0] cmdData,
    input  wire logic        respValid,
    input  wire logic [15:0] respData
);
    // Port idle at time zero
    initial begin
        cmdValid = 1'b0;
        cmdCode  = 4'h0;
        cmdData  = 16'h0000;
    end

    // One command held through its taking edge, answer sampled after it
    task automatic xfer(input status_event_pkg::cmd_t code, input logic [15:0] data,
                        output logic gotValid, output logic [15:0] gotData);
        cmdValid = 1'b1;
        cmdCode  = code;
        cmdData  = data;
        @(posedge clk);
        #1;
        gotValid = respValid;
        gotData  = respData;
    endtask

    // Port released; stale code and data scrambled every cycle
    task automatic rest(input int n);
        cmdValid = 1'b0;
        repeat (n) begin
            cmdData = ~cmdData;
            cmdCode = ~cmdCode;
            @(posedge clk);
            #1;
        end
    endtask
endmodule

`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_event_regs.svh"

module tb_top;
    logic        clk;
    logic        rst_n;
    logic        clkEn;
    logic        cmdValid;
    logic [3:0]  cmdCode;
    logic [15:0] cmdData;
    logic        respValid;
    logic [15:0] respData;
    logic        opcIdle;
    logic [3:0]  errIn;
    logic        summarySourceA;
    logic [15:0] traceFail;
    logic [2:0]  stbIn;
    logic        errPush;
    logic [15:0] errCode;
    logic [7:0]  statusByte;
    logic        individualStatus;
    int          badCount = 0;
    int          cmpCount = 0;

    status_event_aggregator u_status_event_aggregator (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdData(cmdData), .respValid(respValid),
        .respData(respData), .opcIdle(opcIdle), .queryErr(errIn[3]),
        .deviceErr(errIn[2]), .execErr(errIn[1]), .commandErr(errIn[0]),
        .summarySourceA(summarySourceA), .traceFail(traceFail),
        .errQueueNotEmpty(stbIn[2]), .msgAvailable(stbIn[1]),
        .serviceRequest(stbIn[0]), .errPush(errPush), .errCode(errCode),
        .statusByte(statusByte), .individualStatus(individualStatus)
    );

    host_model u_host_model (
        .clk(clk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
        .respValid(respValid), .respData(respData)
    );

    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic wrapUp();
        $display("counts: compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp, input string what);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic idle(input int n);
        u_host_model.rest(n);
    endtask

    task automatic wr(input status_event_pkg::cmd_t c, input logic [15:0] d);
        logic        v;
        logic [15:0] r;
        u_host_model.xfer(c, d, v, r);
        idle(1);
    endtask

    // Read command, answer checked for strobe and value
    task automatic rd(input status_event_pkg::cmd_t c, input logic [15:0] exp, input string what);
        logic        v;
        logic [15:0] r;
        u_host_model.xfer(c, 16'h0000, v, r);
        chkBit(v, 1'b1, what);
        chkVal(r, exp, what);
        idle(1);
    endtask

    // Event inputs high for one enabled edge
    task automatic pulse(input logic [3:0] e, input logic [15:0] tf, input logic ia);
        errIn          = e;
        traceFail      = tf;
        summarySourceA = ia;
        @(posedge clk);
        #1;
        errIn          = 4'h0;
        traceFail      = 16'h0000;
        summarySourceA = 1'b0;
    endtask

    // Event bits from {query, device, exec, command}
    function automatic logic [7:0] expEsr(input logic [3:0] e);
        return {2'b00, e[0], e[1], e[2], e[3], 2'b00};
    endfunction

    function automatic logic [15:0] expCode(input logic [3:0] e);
        if (e[2]) return `SE_ERR_DEVICE;
        if (e[1]) return `SE_ERR_EXEC;
        return `SE_ERR_CMD;
    endfunction

    // Hang guard
    initial begin
        repeat (4000) @(posedge clk);
        badCount++;
        $display("BAD %0t timeout", $time);
        wrapUp();
    end

    // Main sequence
    initial begin
        logic [3:0]  e;
        logic [7:0]  event_status_mask;
        logic [7:0]  pre;
        logic [7:0]  sb;
        logic [15:0] tf;
        logic [15:0] l1;
        logic [15:0] l2;
        logic [15:0] q;
        logic [15:0] l1e;
        logic [15:0] l2e;
        logic [15:0] qe;
        logic        ia;
        logic        v;
        logic [15:0] r;
        rst_n = 1'b0;
        clkEn = 1'b1;
        opcIdle = 1'b0;
        errIn = 4'h0;
        summarySourceA = 1'b0;
        traceFail = 16'h0000;
        stbIn = 3'h0;
        void'($urandom(8784));
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chkVal({8'h00, statusByte}, 16'h0000, "stb reset");
        rd(status_event_pkg::CMD_ESR_RD, 16'h0080, "power on");
        rd(status_event_pkg::CMD_ESR_RD, 16'h0000, "esr cleared");
        rd(status_event_pkg::CMD_ESE_RD, 16'h0000, "ese reset");
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            e = (i < 4) ? (4'h1 << i) : 4'($urandom());
            event_status_mask = 8'($urandom());
            wr(status_event_pkg::CMD_ESE_WR, {8'h00, event_status_mask});
            pulse(e, 16'h0000, 1'b0);
            chkBit(errPush, |e[2:0], "push");
            if (|e[2:0]) chkVal(errCode, expCode(e), "code");
            idle(3);
            chkBit(statusByte[5], |(expEsr(e) & event_status_mask), "esb");
            rd(status_event_pkg::CMD_ESR_RD, {8'h00, expEsr(e)}, "esr");
            rd(status_event_pkg::CMD_ESE_RD, {8'h00, event_status_mask & 8'hBD}, "ese");
        end
        $display("test errors done");
        wr(status_event_pkg::CMD_OPC, 16'h0000);
        idle(4);
        rd(status_event_pkg::CMD_ESR_RD, 16'h0000, "opc early");
        opcIdle = 1'b1;
        idle(3);
        rd(status_event_pkg::CMD_ESR_RD, 16'h0001, "opc");
        wr(status_event_pkg::CMD_OPC, 16'h0000);
        rd(status_event_pkg::CMD_ESR_RD, 16'h0001, "opc ready");
        $display("test opc done");
        for (int i = 0; i < 8; i++) begin
            tf  = (i == 0) ? 16'h4000 : 16'($urandom());
            l2e = (i == 0) ? 16'h0006 : 16'($urandom());
            l1e = (i == 0) ? 16'h0001 : 16'($urandom());
            qe  = (i == 0) ? 16'h0400 : 16'($urandom());
            ia  = (i == 0) ? 1'b0 : 1'($urandom());
            wr(status_event_pkg::CMD_LIM2_EN, l2e);
            wr(status_event_pkg::CMD_LIM1_EN, l1e);
            wr(status_event_pkg::CMD_QUES_EN, qe);
            pulse(4'h0, tf, ia);
            idle(6);
            l2 = {13'h0000, tf[15:14], 1'b0};
            l1 = {1'b0, tf[13:0], |(l2 & l2e)};
            q  = {5'h00, |(l1 & l1e), ia, 9'h000};
            chkBit(statusByte[3], |(q & qe), "ques sum");
            rd(status_event_pkg::CMD_LIM2_RD, l2, "lim2");
            idle(3);
            rd(status_event_pkg::CMD_LIM1_RD, l1, "lim1");
            idle(3);
            rd(status_event_pkg::CMD_QUES_RD, q, "ques");
            idle(3);
            rd(status_event_pkg::CMD_QUES_RD, 16'h0000, "ques clr");
        end
        $display("test limits done");
        for (int i = 0; i < 8; i++) begin
            pre = (i == 0) ? 8'h40 : 8'($urandom());
            stbIn = (i == 0) ? 3'b001 : 3'($urandom());
            wr(status_event_pkg::CMD_PRE_WR, {8'h00, pre});
            idle(3);
            sb = {1'b0, stbIn[0], 1'b0, stbIn[1], 1'b0, stbIn[2], 2'b00};
            chkVal({8'h00, statusByte}, {8'h00, sb}, "stb");
            chkBit(individualStatus, |(sb & pre), "ist");
            rd(status_event_pkg::CMD_IST_RD, {15'h0000, |(sb & pre)}, "ist rd");
            rd(status_event_pkg::CMD_PRE_RD, {8'h00, pre}, "pre rd");
            rd(status_event_pkg::CMD_STB_RD, {8'h00, sb}, "stb rd");
        end
        $display("test poll done");
        wr(status_event_pkg::CMD_ESE_WR, 16'h0001);
        clkEn = 1'b0;
        wr(status_event_pkg::CMD_ESE_WR, 16'h00FF);
        clkEn = 1'b1;
        rd(status_event_pkg::CMD_ESE_RD, 16'h0001, "frozen");
        u_host_model.xfer(status_event_pkg::cmd_t'(4'hF), 16'h0000, v, r);
        chkBit(v, 1'b0, "unknown code");
        idle(1);
        $display("test refusals done");
        // Mid-run reset brings back power-on bit and cleared masks
        rst_n = 1'b0;
        idle(2);
        rst_n = 1'b1;
        rd(status_event_pkg::CMD_ESR_RD, 16'h0080, "power on again");
        rd(status_event_pkg::CMD_ESE_RD, 16'h0000, "ese reset again");
        rd(status_event_pkg::CMD_PRE_RD, 16'h0000, "pre reset again");
        $display("test second reset done");
        wrapUp();
    end
endmodule

`default_nettype wire
